/* File: sim/sar_host_model.sv */
`timescale 1ns/100ps
module sar_host_model (
   // Clock and serial pins
   input  wire logic        i_clk,
   input  wire logic        i_sdo,
   output logic             o_convert_request_n,
   output logic             o_sck,
   output logic [14:0]      o_word
);
   // ------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------
   task automatic wait_n(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // Serial clock stands low between frames; a short count aborts the frame.
   task automatic convert(input int pulses);
      o_word = 15'h0000;
      wait_n(1);
      o_convert_request_n = 1'b0;
      wait_n(12);
      for (int k = 0; k < pulses; k++) begin
         o_sck = 1'b1;
         wait_n(4);
         o_sck = 1'b0;
         wait_n(4);
         o_word = {o_word[13:0], i_sdo};
      end
      wait_n(2);
      o_convert_request_n = 1'b1;
      wait_n(6);
   endtask

   initial begin
      o_convert_request_n = 1'b1;
      o_sck = 1'b0;
      o_word = 15'h0000;
   end
endmodule // sar_host_model

/* File: sim/sar_readout_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sar_readout_tb;
   logic        i_clk, i_rst, i_res_ready, stall;
   logic        cnv_n, sck, o_sdo, o_sdo_oe_n, o_acquiring, o_res_valid, sdo_pin;
   logic [14:0] i_sample_code, o_res_data, code;
   logic [14:0] expq[$];
   logic [14:0] gotq[$];
   logic [14:0] corner[5] = '{15'h4000, 15'h3fff, 15'h0000, 15'h7fff, 15'h0001};
   int          n_mismatch, n_checks, seed, cycles;

   // ------------------------------------------------
   // Design and host
   // ------------------------------------------------
   sar_readout i_sar_readout (.i_clk(i_clk), .i_rst(i_rst), .i_convert_request_n(cnv_n),
      .i_sck(sck), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .i_sample_code(i_sample_code),
      .o_acquiring(o_acquiring), .o_res_valid(o_res_valid), .o_res_data(o_res_data),
      .i_res_ready(i_res_ready));
   // A released line shows the inverse so a stale bit can never be captured.
   assign sdo_pin = o_sdo_oe_n ? ~o_sdo : o_sdo;
   sar_host_model i_sar_host_model (.i_clk(i_clk), .i_sdo(sdo_pin),
      .o_convert_request_n(cnv_n), .o_sck(sck), .o_word());

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(negedge i_clk) i_res_ready <= !stall && (($random(seed) & 32'sh1) != 0);
   always @(posedge i_clk) begin
      if (o_res_valid && i_res_ready) gotq.push_back(o_res_data);
      cycles++;
      if (cycles == 12000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   function automatic logic neg(input logic [14:0] c);
      return $signed(c) < 0;
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------
   // One conversion with the sample held steady
   // ------------------------------------------------
   task automatic run(input logic [14:0] c, input int pulses);
      @(negedge i_clk);
      i_sample_code = c;
      repeat (4) @(negedge i_clk);
      fork
         i_sar_host_model.convert(pulses);
         begin
            repeat (20) @(negedge i_clk);
            `CHK("oe_n conv", 1'b0, o_sdo_oe_n)
            `CHK("acq conv", 1'b0, o_acquiring)
         end
      join
      if (pulses == 15) begin
         `CHK("serial", c, i_sar_host_model.o_word)
         `CHK("sign", neg(c), i_sar_host_model.o_word[14])
         expq.push_back(c);
      end
      `CHK("oe_n idle", 1'b1, o_sdo_oe_n)
      `CHK("acq idle", 1'b1, o_acquiring)
   endtask

   initial begin
      seed = 83;
      i_rst = 1'b1;
      stall = 1'b0;
      i_sample_code = 15'h0000;
      i_res_ready = 1'b1;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      `CHK("rst oe_n", 1'b1, o_sdo_oe_n)
      `CHK("rst valid", 1'b0, o_res_valid)
      foreach (corner[i]) run(corner[i], 15);
      $display("test corner codes done");
      run(15'h1234, 7);
      run(15'h0abc, 15);
      $display("test abort done");
      stall = 1'b1;
      for (int i = 0; i < 3; i++) begin
         code = 15'($random(seed));
         run(code, 15);
      end
      `CHK("stall valid", 1'b1, o_res_valid)
      stall = 1'b0;
      $display("test stall done");
      for (int i = 0; i < 10; i++) begin
         code = 15'($random(seed));
         run(code, 15);
      end
      repeat (40) @(negedge i_clk);
      `CHK("words", expq.size(), gotq.size())
      foreach (expq[i]) if (i < gotq.size()) `CHK("word", expq[i], gotq[i])
      $display("test random stream done");
      give_verdict();
   end
endmodule // sar_readout_tb

/* File: src/sar_pkg.sv */
package sar_pkg;
   // -----------------------------------------------------------------
   // Result word and sequencing
   // -----------------------------------------------------------------
   localparam int          RES_W      = 15;
   localparam int          STEP_W     = 4;
   localparam logic [3:0]  LAST_STEP  = 4'hf;
   localparam logic [14:0] SIGN_FLIP  = 15'h4000;
   localparam logic [14:0] DAC_RST    = 15'h0000;
   localparam logic [14:0] TOP_WEIGHT = 15'h4000;

   // -----------------------------------------------------------------
   // Host timing
   // -----------------------------------------------------------------
   localparam int CLK_NS    = 20;
   localparam int QUIET_NS  = 220;
   localparam int QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_ACQ  = 1'b0,
      ST_CONV = 1'b1
   } sar_phase_t;

   typedef struct packed {
      logic              valid;
      logic [RES_W-1:0]  code;
   } sar_word_t;
endpackage

/* File: src/sar_readout.sv */
`timescale 1ns/100ps
// How it works
// - Device alternates between acquisition (tracking) and conversion (held sample) phases.
// - Falling convert_request_n ends acquisition and starts a conversion.
// - Each of the first 15 serial clock pulses advances the capacitive_dac by one approximation step.
// - A conversion ends with a 15-bit word, 14 magnitude bits plus sign.
// - Serial data changes to the next bit on each serial clock falling edge.
// - Result is two's complement; negative inputs set the top bit.
// - Full span of twice reference_output maps onto 2^15 equal codes.
// - Bits shifted after a request belong to that same conversion, no latency.
// - Result leaves most significant bit first, then lower bits descending.
// - Data output released when request rises, driven again when it falls.
module sar_readout (
   // -----------------------------------------------------------------
   // Clock and reset
   // -----------------------------------------------------------------
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // -----------------------------------------------------------------
   // Host pins
   // -----------------------------------------------------------------
   input  wire logic              i_convert_request_n,
   input  wire logic              i_sck,
   output logic                   o_sdo,
   output logic                   o_sdo_oe_n,
   // -----------------------------------------------------------------
   // Analog model: differential input as a signed code
   // -----------------------------------------------------------------
   input  wire logic [14:0]       i_sample_code,
   output logic                   o_acquiring,
   // -----------------------------------------------------------------
   // Parallel result stream
   // -----------------------------------------------------------------
   output logic                   o_res_valid,
   output logic [14:0]            o_res_data,
   input  wire logic              i_res_ready
);
   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic        cnv_s1_r;
   logic        cnv_s2_r;
   logic        cnv_d_r;
   logic        sck_s1_r;
   logic        sck_s2_r;
   logic        sck_d_r;
   logic [14:0] smp_s1_r;
   logic [14:0] smp_s2_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnv_s1_r <= 1'b1;
         cnv_s2_r <= 1'b1;
         cnv_d_r  <= 1'b1;
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_d_r  <= 1'b0;
         smp_s1_r <= 15'h0000;
         smp_s2_r <= 15'h0000;
      end else begin
         cnv_s1_r <= i_convert_request_n;
         cnv_s2_r <= cnv_s1_r;
         cnv_d_r  <= cnv_s2_r;
         sck_s1_r <= i_sck;
         sck_s2_r <= sck_s1_r;
         sck_d_r  <= sck_s2_r;
         smp_s1_r <= i_sample_code;
         smp_s2_r <= smp_s1_r;
      end
   end

   wire cnv_fall = cnv_d_r & ~cnv_s2_r;
   wire cnv_rise = ~cnv_d_r & cnv_s2_r;
   wire sck_rise = sck_s2_r & ~sck_d_r;
   wire sck_fall = ~sck_s2_r & sck_d_r;

   // -----------------------------------------------------------------
   // Approximation datapath
   // -----------------------------------------------------------------
   sar_pkg::sar_phase_t state_r;
   logic [14:0]         sample_r;
   logic [14:0]         dac_r;
   logic [3:0]          step_r;
   logic                bit_r;
   logic                sdo_r;
   logic                oe_n_r;
   sar_pkg::sar_word_t  pend_r;
   logic                acq_r;

   // The held sample is compared in offset binary so a plain unsigned
   // comparison does the job; the sign bit is flipped back on output.
   wire [14:0] target   = sample_r ^ sar_pkg::SIGN_FLIP;
   wire [14:0] weight   = sar_pkg::TOP_WEIGHT >> step_r;
   wire [14:0] trial    = dac_r | weight;
   wire        keep     = (target >= trial);
   wire [14:0] dac_nxt  = keep ? trial : dac_r;
   wire        in_conv  = (state_r == sar_pkg::ST_CONV);
   wire        do_step  = in_conv & sck_rise & (step_r != sar_pkg::LAST_STEP) & ~cnv_rise;
   wire        do_shift = in_conv & sck_fall & (step_r != 4'h0) & ~cnv_rise;
   wire        msb_out  = (step_r == 4'h1);
   wire        finish   = do_step & (step_r == sar_pkg::LAST_STEP - 4'h1);
   wire        buf_in_rdy;
   wire        push     = pend_r.valid & buf_in_rdy;

   // The phase flag has its own flop so the pin never shows a decode.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r  <= sar_pkg::ST_ACQ;
         acq_r    <= 1'b1;
         sample_r <= 15'h0000;
         dac_r    <= sar_pkg::DAC_RST;
         step_r   <= 4'h0;
         bit_r    <= 1'b0;
      end else if (cnv_rise) begin
         state_r  <= sar_pkg::ST_ACQ;
         acq_r    <= 1'b1;
      end else if (cnv_fall) begin
         state_r  <= sar_pkg::ST_CONV;
         acq_r    <= 1'b0;
         sample_r <= smp_s2_r;
         dac_r    <= sar_pkg::DAC_RST;
         step_r   <= 4'h0;
      end else if (do_step) begin
         dac_r    <= dac_nxt;
         bit_r    <= keep;
         step_r   <= step_r + 4'h1;
      end else if (!in_conv) begin
         sample_r <= smp_s2_r;
      end
   end

   // Bits leave as they are decided, so the word on the wire is this
   // conversion's word; only the first bit is inverted back to a sign.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sdo_r  <= 1'b0;
         oe_n_r <= 1'b1;
      end else if (cnv_rise) begin
         oe_n_r <= 1'b1;
      end else if (cnv_fall) begin
         oe_n_r <= 1'b0;
         sdo_r  <= 1'b0;
      end else if (do_shift) begin
         sdo_r  <= bit_r ^ msb_out;
      end
   end

   // A finished word waits here while the buffer is full; a further
   // word arriving before it drains replaces it.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_r <= '0;
      end else if (finish) begin
         pend_r.valid <= 1'b1;
         pend_r.code  <= dac_nxt ^ sar_pkg::SIGN_FLIP;
      end else if (push) begin
         pend_r.valid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Two-entry output buffer
   // -----------------------------------------------------------------
   sar_pkg::sar_word_t out_r;
   sar_pkg::sar_word_t skid_r;

   wire pop       = out_r.valid & i_res_ready;
   wire out_free  = ~out_r.valid | pop;
   assign buf_in_rdy = ~skid_r.valid;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         out_r  <= '0;
         skid_r <= '0;
      end else if (out_free) begin
         out_r        <= skid_r.valid ? skid_r : (push ? pend_r : '0);
         skid_r.valid <= skid_r.valid & push;
         skid_r.code  <= pend_r.code;
      end else if (push) begin
         skid_r <= pend_r;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign o_sdo       = sdo_r;
   assign o_sdo_oe_n  = oe_n_r;
   assign o_acquiring = acq_r;
   assign o_res_valid = out_r.valid;
   assign o_res_data  = out_r.code;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   // The step counter, weights and sign flip are sized for this word only.
   if (sar_pkg::RES_W != 15) begin : g_bad_width
      $error("result word must be 15 bits wide");
   end
   if ((1 << sar_pkg::STEP_W) <= sar_pkg::RES_W) begin : g_bad_step
      $error("step counter too narrow for the result word");
   end
   if (int'(sar_pkg::LAST_STEP) != sar_pkg::RES_W) begin : g_bad_last
      $error("last step must equal the result width");
   end
   if (sar_pkg::SIGN_FLIP != sar_pkg::TOP_WEIGHT) begin : g_bad_sign
      $error("sign flip must be the top weight");
   end

   // -----------------------------------------------------------------
   // Shift bookkeeping for the checks
   // -----------------------------------------------------------------
   // Counts bits put on the wire since the request fell; it saturates so
   // an overlong host burst cannot wrap it back into the legal range.
   logic [4:0] shift_cnt_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_cnt_r <= 5'h00;
      end else if (cnv_fall) begin
         shift_cnt_r <= 5'h00;
      end else if (do_shift && (shift_cnt_r != 5'h1f)) begin
         shift_cnt_r <= shift_cnt_r + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_conv_on_fall: assert property (cnv_fall |=> in_conv)
      else $error("conversion did not start on request fall");
   a_acq_on_rise: assert property (cnv_rise |=> !in_conv ##1 !in_conv)
      else $error("acquisition did not resume on request rise");
   a_step_count: assert property (do_step |=> step_r == $past(step_r) + 4'h1)
      else $error("approximation step did not advance");
   a_acq_flag: assert property (acq_r == (state_r == sar_pkg::ST_ACQ))
      else $error("phase flag differs from the phase");
   a_step_idle: assert property (!in_conv && !cnv_fall |=> $stable(step_r))
      else $error("step moved outside a conversion");
   a_step_limit: assert property (in_conv && step_r == sar_pkg::LAST_STEP |=> step_r == sar_pkg::LAST_STEP)
      else $error("step advanced past the last bit");
   a_keep_bit: assert property (do_step |=> bit_r == $past(keep))
      else $error("decided bit not kept");
   a_dac_clear: assert property (cnv_fall |=> dac_r == sar_pkg::DAC_RST && step_r == 4'h0)
      else $error("approximation not cleared at request fall");
   a_sample_frozen: assert property (in_conv |=> $stable(sample_r))
      else $error("held sample moved during conversion");

   // -----------------------------------------------------------------
   // Serial pin checks
   // -----------------------------------------------------------------
   a_sdo_when: assert property ($changed(sdo_r) |-> $past(do_shift) || $past(cnv_fall))
      else $error("serial data changed outside a falling clock edge");
   a_sign_first: assert property (do_shift && msb_out |=> sdo_r == sample_r[14])
      else $error("first bit is not the sign of the sample");
   a_shift_bound: assert property (in_conv |-> shift_cnt_r <= {1'b0, step_r})
      else $error("a bit left before it was decided");
   a_first_zero: assert property (cnv_fall |=> !sdo_r)
      else $error("serial data not low before the first bit");
   a_bus_release: assert property (cnv_rise |=> oe_n_r ##1 oe_n_r)
      else $error("data output not released");
   a_bus_drive: assert property (cnv_fall |=> !oe_n_r)
      else $error("data output not driven after request fall");
   a_oe_phase: assert property (oe_n_r == (state_r == sar_pkg::ST_ACQ))
      else $error("output enable differs from the phase");

   // -----------------------------------------------------------------
   // Stream checks
   // -----------------------------------------------------------------
   a_word_match: assert property (finish |=> pend_r.code == sample_r)
      else $error("result word differs from the held sample");
   a_pend_set: assert property (finish |=> pend_r.valid)
      else $error("finished word not pending");
   a_no_word_abort: assert property (!finish |=> !$rose(pend_r.valid))
      else $error("word produced without a full conversion");
   a_skid_load: assert property (push && !out_free |=> skid_r.valid && skid_r.code == $past(pend_r.code))
      else $error("stalled word not held in the second entry");
   a_skid_order: assert property (out_free && skid_r.valid |=> out_r.valid && out_r.code == $past(skid_r.code))
      else $error("second entry not moved forward in order");
   a_skid_only_full: assert property (skid_r.valid |-> out_r.valid)
      else $error("second entry filled while the first is empty");
   a_buf_hold: assert property (out_r.valid && !i_res_ready |=> out_r.valid && $stable(out_r.code))
      else $error("buffered word changed while stalled");

   // -----------------------------------------------------------------
   // Coverage
   // -----------------------------------------------------------------
   c_full_conv: cover property (finish);
   c_buf_full: cover property (skid_r.valid && out_r.valid);
   c_abort: cover property (in_conv && cnv_rise && step_r != 4'h0);
   c_word_taken: cover property (pop);
   c_neg_sign: cover property (do_shift && msb_out && sample_r[14]);
endmodule // sar_readout
